// >>> pkg/iocsd_defines.svh
// I/O chip select decoder: port addresses, field positions, codes.
// Assumes inclusion by bare name from the package and design files.
`ifndef IOCSD_DEFINES_SVH
`define IOCSD_DEFINES_SVH
`define IOCSD_PORT_SERSEL 16'h2072
`define IOCSD_PORT_TIMCTL 16'h2872
`define IOCSD_PORT_PADDR 16'h3072
`define IOCSD_PORT_FLUSH 16'hF872
`define IOCSD_PORT_LOCK 16'h0092
`define IOCSD_TIMCTL_MASK 16'hBFDF
`define IOCSD_SERSEL_MASK 16'h0FFF
`define IOCSD_RST_REG 16'h0000
`define IOCSD_T_RTC_L 15
`define IOCSD_T_QUICK 13
`define IOCSD_T_PEN 12
`define IOCSD_T_UPPER 11
`define IOCSD_T_LOW_HI 10
`define IOCSD_T_LOW_LO 8
`define IOCSD_T_SIDE 7
`define IOCSD_T_FDISK 6
`define IOCSD_T_PS 4
`define IOCSD_T_COPRO 3
`define IOCSD_T_PWINH 2
`define IOCSD_T_HDOFF 1
`define IOCSD_T_FLPOFF 0
`define IOCSD_S_SCSI 11
`define IOCSD_S_PAR_L 8
`define IOCSD_S_SER1_L 4
`define IOCSD_S_SER2_L 0
`define IOCSD_LOCK_BIT 3
`define IOCSD_WS_SLOW 3'h4
`define IOCSD_WS_FAST 3'h1
`define IOCSD_WS_NONE 3'h0
`define IOCSD_LOW_MAX 3'h4
`define IOCSD_CS_KBD 5'h01
`define IOCSD_CS_COPRO 5'h02
`define IOCSD_CS_RTC_ALE 5'h05
`define IOCSD_CS_RTC_WR 5'h06
`define IOCSD_CS_RTC_RD 5'h07
`define IOCSD_CS_FLP_OP 5'h08
`define IOCSD_CS_FLP 5'h09
`define IOCSD_CS_FLP_CTL 5'h0A
`define IOCSD_CS_FLPHD_CTL 5'h0B
`define IOCSD_CS_HD 5'h0C
`define IOCSD_CS_HD_IDE 5'h0D
`define IOCSD_CS_SER1 5'h0E
`define IOCSD_CS_PAR 5'h0F
`define IOCSD_CS_SER2 5'h10
`define IOCSD_CS_PROG 5'h11
`define IOCSD_CS_SCSI 5'h12
`define IOCSD_CS_FLUSH 5'h13
`define IOCSD_CS_IDLE 5'h1F
`endif

// >>> pkg/iocsd_pkg.sv
// Types shared by the I/O chip select decoder files.
// Assumes the defines header is on the include path.
package iocsd_pkg;
  `include "iocsd_defines.svh"
  typedef logic [4:0] iocsd_code_t;
  typedef enum logic {
    HD_COMPAT = 1'b0,
    HD_STREAM = 1'b1
  } iocsd_hd_state_t;
endpackage : iocsd_pkg

// >>> rtl/iocsd_decoder.sv
// I/O chip select decoder: control ports and encoded select output.
// Assumes host I/O strobes are one-cycle pulses on the core clock.
// Overview of operation
// - SCSI byte accesses get four wait states, one when quick bit set.
// - Programmable select code 11 only while its enable bit is set.
// - Programmable select compares address against its 16-bit register.
// - Upper compare bit zero ignores A15..A10 in programmable match.
// - Low ignore field skips zero to four low bits in the match.
// - Bus side bit puts programmable peripheral on local or expansion bus.
// - Fast disk: first data transfer compatible, later ones compressed until another cycle intervenes.
// - Bank bit picks primary or secondary floppy and disk addresses.
// - Coprocessor cycles use 8-bit timing, 16-bit when fast bit set.
// - Inhibit set first blocks the password lock; a set lock stays.
// - Disk select off bit suppresses codes 0C and 0D.
// - Floppy select off bit suppresses codes 08 through 0B.
// - Any write to the flush port yields code 13.
// - Three-digit fixed ports except the coprocessor range ignore A15..A10.
// - Selection is a 5-bit binary code, not one-hot strobes.
// - Same range on both serial selects: only the first one fires.
// - Even ports 060..06E give keyboard code 01.
// - Ports 00E0..00FF give coprocessor code 02.
// - Floppy control port gives 0A with disk off, 0B with disk on outside IDE mode.
// - IDE mode: disk control ports give code 0D.
// - Serial field: off, 3F8, 2F8, 3E8, 2E8 ranges.
// - Printer field: off, 3BC-3BF, 378-37F, 278-27F.
`timescale 1ns/1ps
`include "iocsd_defines.svh"
module iocsd_decoder
  import iocsd_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [15:0] io_wdata_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic ide_mode_i,
  output logic [15:0] io_rdata_o,
  output iocsd_code_t select_code_lines_o,
  output logic [2:0] wait_states_o,
  output logic bus_16bit_o,
  output logic expansion_bus_o,
  output logic hd_compressed_o,
  output logic password_area_open_o
);
  logic [15:0] timctl;
  logic [15:0] sersel;
  logic [15:0] paddr;
  logic lock;
  logic [15:0] next_timctl;
  logic [15:0] next_sersel;
  logic [15:0] next_paddr;
  logic next_lock;
  logic ide_s1;
  logic ide_s2;
  logic cyc;
  logic [9:0] a10;
  logic [9:0] dbase;
  logic prog_hit;
  logic hd_data;
  logic hd_fast;
  logic ser1_hit;
  logic ser2_hit;
  logic par_hit;
  logic scsi_hit;
  iocsd_code_t next_code;
  logic [2:0] next_ws;
  logic next_b16;
  logic next_exp;
  logic [15:0] next_rdata;

  assign cyc = io_rd_i || io_wr_i;
  assign a10 = io_addr_i[9:0];
  assign dbase = timctl[`IOCSD_T_PS] ? 10'h370 : 10'h3F0;

  function automatic logic ser_match(input logic [2:0] sel,
                                     input logic [9:0] a);
    logic [9:0] base;
    base = 10'h000;
    unique case (sel)
      3'h1: base = 10'h3F8;
      3'h2: base = 10'h2F8;
      3'h3: base = 10'h3E8;
      3'h4: base = 10'h2E8;
      default: base = 10'h000;
    endcase
    ser_match = (base != 10'h000) && (a[9:3] == base[9:3]);
  endfunction : ser_match

  function automatic logic par_match(input logic [1:0] sel,
                                     input logic [9:0] a);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      2'h0: hit = 1'b0;
      2'h1: hit = (a[9:2] == 8'hEF);
      2'h2: hit = (a[9:3] == 7'h6F);
      2'h3: hit = (a[9:3] == 7'h4F);
    endcase
    par_match = hit;
  endfunction : par_match

  assign ser1_hit = ser_match(sersel[7:5], a10);
  assign ser2_hit = ser_match(sersel[3:1], a10);
  assign par_hit = par_match(sersel[10:9], a10);
  assign scsi_hit = sersel[`IOCSD_S_SCSI] && (io_addr_i[15:4] == 12'h353);
  assign hd_data = !timctl[`IOCSD_T_HDOFF]
                   && (a10 == (dbase - 10'h200));

  iocsd_prog_match u_prog (
    .addr_i(io_addr_i),
    .base_i(paddr),
    .enable_i(timctl[`IOCSD_T_PEN]),
    .upper_i(timctl[`IOCSD_T_UPPER]),
    .low_ign_i(timctl[`IOCSD_T_LOW_HI:`IOCSD_T_LOW_LO]),
    .hit_o(prog_hit)
  );

  iocsd_hd_timing u_hd (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .access_i(cyc),
    .hd_data_i(hd_data),
    .fast_en_i(timctl[`IOCSD_T_FDISK]),
    .compressed_o(hd_fast)
  );

  // Control ports
  always_comb begin
    next_timctl = timctl;
    next_sersel = sersel;
    next_paddr = paddr;
    next_lock = lock;
    if (io_wr_i) begin
      if (io_addr_i == `IOCSD_PORT_TIMCTL) begin
        next_timctl = io_wdata_i & `IOCSD_TIMCTL_MASK;
      end
      if (io_addr_i == `IOCSD_PORT_SERSEL) begin
        next_sersel = io_wdata_i & `IOCSD_SERSEL_MASK;
      end
      if (io_addr_i == `IOCSD_PORT_PADDR) begin
        next_paddr = io_wdata_i;
      end
      if (io_addr_i == `IOCSD_PORT_LOCK && io_wdata_i[`IOCSD_LOCK_BIT]
          && !timctl[`IOCSD_T_PWINH]) begin
        next_lock = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      timctl <= `IOCSD_RST_REG;
      sersel <= `IOCSD_RST_REG;
      paddr <= `IOCSD_RST_REG;
      lock <= 1'b0;
      ide_s1 <= 1'b0;
      ide_s2 <= 1'b0;
    end else begin
      timctl <= next_timctl;
      sersel <= next_sersel;
      paddr <= next_paddr;
      lock <= next_lock;
      ide_s1 <= ide_mode_i;
      ide_s2 <= ide_s1;
    end
  end

  // Decode, fixed ports ahead of the programmable one
  always_comb begin
    next_code = `IOCSD_CS_IDLE;
    next_ws = `IOCSD_WS_NONE;
    next_b16 = 1'b0;
    next_exp = 1'b0;
    next_rdata = 16'h0000;
    if (io_rd_i) begin
      unique case (io_addr_i)
        `IOCSD_PORT_TIMCTL: next_rdata = timctl;
        `IOCSD_PORT_SERSEL: next_rdata = sersel;
        `IOCSD_PORT_PADDR: next_rdata = paddr;
        `IOCSD_PORT_LOCK: next_rdata = 16'(lock) << `IOCSD_LOCK_BIT;
        default: next_rdata = 16'h0000;
      endcase
    end
    if (cyc) begin
      if (a10[9:4] == 6'h06 && !a10[0]) begin
        next_code = `IOCSD_CS_KBD;
      end else if (io_addr_i[15:5] == 11'h007) begin
        next_code = `IOCSD_CS_COPRO;
        next_b16 = timctl[`IOCSD_T_COPRO];
      end else if (a10[9:1] == 9'h038) begin
        next_exp = timctl[`IOCSD_T_RTC_L];
        if (!a10[0]) begin
          next_code = `IOCSD_CS_RTC_ALE;
        end else if (io_wr_i) begin
          next_code = `IOCSD_CS_RTC_WR;
        end else begin
          next_code = `IOCSD_CS_RTC_RD;
        end
      end else if (hd_data || (!timctl[`IOCSD_T_HDOFF]
                   && a10[9:3] == 7'(((dbase - 10'h200) >> 3)))) begin
        next_code = `IOCSD_CS_HD;
        next_b16 = hd_data;
      end else if (ide_s2 && !timctl[`IOCSD_T_HDOFF]
                   && a10[9:1] == 9'(((dbase + 10'h006) >> 1))) begin
        next_code = `IOCSD_CS_HD_IDE;
      end else if (!timctl[`IOCSD_T_FLPOFF]
                   && a10[9:3] == dbase[9:3]
                   && (a10[2:0] == 3'h2 || a10[2:0] == 3'h4
                       || a10[2:0] == 3'h5 || a10[2:0] == 3'h7)) begin
        unique case (a10[2:0])
          3'h2: next_code = `IOCSD_CS_FLP_OP;
          3'h7: begin
            next_code = timctl[`IOCSD_T_HDOFF] ? `IOCSD_CS_FLP_CTL
                                                : `IOCSD_CS_FLPHD_CTL;
          end
          default: next_code = `IOCSD_CS_FLP;
        endcase
      end else if (ser1_hit) begin
        next_code = `IOCSD_CS_SER1;
        next_exp = sersel[`IOCSD_S_SER1_L];
      end else if (par_hit) begin
        next_code = `IOCSD_CS_PAR;
        next_exp = sersel[`IOCSD_S_PAR_L];
      end else if (ser2_hit) begin
        next_code = `IOCSD_CS_SER2;
        next_exp = sersel[`IOCSD_S_SER2_L];
      end else if (scsi_hit) begin
        next_code = `IOCSD_CS_SCSI;
        next_ws = timctl[`IOCSD_T_QUICK] ? `IOCSD_WS_FAST : `IOCSD_WS_SLOW;
      end else if (io_wr_i && io_addr_i == `IOCSD_PORT_FLUSH) begin
        next_code = `IOCSD_CS_FLUSH;
      end else if (prog_hit && io_addr_i != `IOCSD_PORT_FLUSH) begin
        next_code = `IOCSD_CS_PROG;
        next_exp = timctl[`IOCSD_T_SIDE];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      select_code_lines_o <= `IOCSD_CS_IDLE;
      wait_states_o <= `IOCSD_WS_NONE;
      bus_16bit_o <= 1'b0;
      expansion_bus_o <= 1'b0;
      hd_compressed_o <= 1'b0;
      io_rdata_o <= 16'h0000;
      password_area_open_o <= 1'b1;
    end else begin
      select_code_lines_o <= next_code;
      wait_states_o <= next_ws;
      bus_16bit_o <= next_b16;
      expansion_bus_o <= next_exp;
      hd_compressed_o <= hd_fast;
      io_rdata_o <= next_rdata;
      password_area_open_o <= !lock;
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  scsi_wait_count_a: assert property (
    (cyc && scsi_hit && next_code == `IOCSD_CS_SCSI) |=>
    wait_states_o == ($past(timctl[`IOCSD_T_QUICK]) ? 3'h1 : 3'h4))
    else $error("wrong SCSI wait states");
  prog_enable_a: assert property (
    select_code_lines_o == `IOCSD_CS_PROG |-> $past(timctl[`IOCSD_T_PEN]))
    else $error("programmable select while disabled");
  copro_timing_a: assert property (
    (cyc && io_addr_i[15:5] == 11'h007) |=>
    select_code_lines_o == 5'h02 && bus_16bit_o == $past(timctl[3]))
    else $error("coprocessor code or width wrong");
  lock_inhibit_a: assert property (
    (!lock && timctl[`IOCSD_T_PWINH]) |=> !lock)
    else $error("password lock set while inhibited");
  disk_off_a: assert property (
    (select_code_lines_o inside {5'h0C, 5'h0D}) |-> !$past(timctl[1]))
    else $error("disk select while disabled");
  floppy_off_a: assert property (
    (select_code_lines_o inside {[5'h08:5'h0B]}) |-> !$past(timctl[0]))
    else $error("floppy select while disabled");
  flush_write_a: assert property (
    (io_addr_i == 16'hF872 && cyc) |=>
    (select_code_lines_o == 5'h13) == $past(io_wr_i))
    else $error("flush code not tied to a write");
  serial_first_a: assert property (
    (cyc && ser1_hit && ser2_hit && a10[9:4] != 6'h06) |=>
    select_code_lines_o != `IOCSD_CS_SER2)
    else $error("second serial select not suppressed");
  keyboard_code_a: assert property (
    (cyc && a10[9:4] == 6'h06 && !a10[0]) |=> select_code_lines_o == 5'h01)
    else $error("keyboard code missing");
  idle_code_a: assert property (
    !cyc |=> select_code_lines_o == 5'h1F)
    else $error("select code outside an I/O cycle");
  prog_side_a: assert property (
    select_code_lines_o == `IOCSD_CS_PROG |->
    expansion_bus_o == $past(timctl[`IOCSD_T_SIDE]))
    else $error("programmable select on the wrong bus");
  bank_select_a: assert property (
    (cyc && timctl[`IOCSD_T_PS] && a10 == 10'h3F2) |=>
    select_code_lines_o != `IOCSD_CS_FLP_OP)
    else $error("primary floppy select in secondary bank");
  lock_open_a: assert property (
    lock |=> !password_area_open_o)
    else $error("password area open while locked");
  prog_suppress_a: assert property (
    (cyc && prog_hit && a10[9:4] == 6'h06 && !a10[0]) |=>
    select_code_lines_o == `IOCSD_CS_KBD)
    else $error("programmable select beat a fixed decode");
  floppy_ctl_a: assert property (
    (cyc && !ide_s2 && !timctl[`IOCSD_T_FLPOFF] && !timctl[`IOCSD_T_PS]
     && a10 == 10'h3F7) |=>
    select_code_lines_o == ($past(timctl[`IOCSD_T_HDOFF]) ? 5'h0A : 5'h0B))
    else $error("floppy control code wrong");
  ide_ctl_a: assert property (
    (cyc && ide_s2 && !timctl[`IOCSD_T_HDOFF] && !timctl[`IOCSD_T_PS]
     && a10[9:1] == 9'h1FB) |=> select_code_lines_o == 5'h0D)
    else $error("IDE control code missing");
  serial_range_a: assert property (
    (cyc && sersel[7:5] == 3'h1 && a10[9:3] == 7'h7F) |=> select_code_lines_o == 5'h0E)
    else $error("first serial range not decoded");

  prog_hit_cv: cover property (select_code_lines_o == `IOCSD_CS_PROG);
  ser_clash_cv: cover property (cyc && ser1_hit && ser2_hit);
  lock_set_cv: cover property (!lock ##1 lock);
  hd_fast_cv: cover property (hd_compressed_o);
endmodule : iocsd_decoder

// >>> rtl/iocsd_hd_timing.sv
// Tracks hard-disk data port streaming for compressed timing.
// Assumes one access pulse per host I/O cycle on the core clock.
`timescale 1ns/1ps
module iocsd_hd_timing
  import iocsd_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic access_i,
  input wire logic hd_data_i,
  input wire logic fast_en_i,
  output logic compressed_o
);
  iocsd_hd_state_t state;
  iocsd_hd_state_t next_state;
  logic data_acc;
  assign data_acc = access_i && hd_data_i && fast_en_i;
  assign compressed_o = data_acc && (state == HD_STREAM);
  always_comb begin
    next_state = state;
    unique case (state)
      HD_COMPAT: begin
        if (data_acc) begin
          next_state = HD_STREAM;
        end
      end
      HD_STREAM: begin
        // Any other cycle breaks the stream, so the next one is compatible
        if (access_i && !data_acc) begin
          next_state = HD_COMPAT;
        end
      end
    endcase
  end
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= HD_COMPAT;
    end else begin
      state <= next_state;
    end
  end
  first_slow_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (data_acc && state == HD_COMPAT) |-> !compressed_o ##1 state == HD_STREAM)
    else $error("first disk transfer was not compatible");
  stream_cv: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
    data_acc ##1 data_acc ##1 data_acc);
endmodule : iocsd_hd_timing

// >>> rtl/iocsd_prog_match.sv
// Address comparator for the programmable select.
// Assumes all inputs are on the core clock; purely combinational.
`timescale 1ns/1ps
`include "iocsd_defines.svh"
module iocsd_prog_match
  import iocsd_pkg::*;
(
  input wire logic [15:0] addr_i,
  input wire logic [15:0] base_i,
  input wire logic enable_i,
  input wire logic upper_i,
  input wire logic [2:0] low_ign_i,
  output logic hit_o
);
  logic [2:0] ign;
  logic [15:0] bit_ok;
  // Codes above four are undefined; treat them as the widest mask
  assign ign = (low_ign_i > `IOCSD_LOW_MAX) ? `IOCSD_LOW_MAX : low_ign_i;
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_bit
      if (i >= 10) begin : g_up
        assign bit_ok[i] = !upper_i || (addr_i[i] == base_i[i]);
      end else begin : g_lo
        assign bit_ok[i] = (32'(ign) > i) || (addr_i[i] == base_i[i]);
      end
    end
  endgenerate
  assign hit_o = enable_i && (&bit_ok);
endmodule : iocsd_prog_match

// >>> tb/iocsd_host_model.sv
// Host processor model: issues single I/O cycles to the decoder.
// Assumes one core clock; request lines change just after rising edges.
`timescale 1ns/1ps
module iocsd_host_model (
  input wire logic core_clk_i,
  output logic [15:0] io_addr_o,
  output logic [15:0] io_wdata_o,
  output logic io_rd_o,
  output logic io_wr_o
);
  initial begin
    io_addr_o = 16'h0000;
    io_wdata_o = 16'h0000;
    io_rd_o = 1'b0;
    io_wr_o = 1'b0;
  end
  // Released lines show the inverse so a stale address never fakes a hit
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    io_rd_o <= ~wr;
    io_wr_o <= wr;
    io_addr_o <= a;
    io_wdata_o <= d;
    @(posedge core_clk_i);
    io_rd_o <= 1'b0;
    io_wr_o <= 1'b0;
    io_addr_o <= ~a;
    io_wdata_o <= ~d;
    #1;
  endtask : xfer
endmodule : iocsd_host_model

// >>> tb/testbench.sv
// Self-checking bench for the I/O chip select decoder.
// Assumes the host model drives every I/O cycle; outputs checked 1 ns after.
`timescale 1ns/1ps
`include "iocsd_defines.svh"
module testbench
  import iocsd_pkg::*;
;
  logic core_clk_i, rstn_i, ide_mode_i, rd, wr, b16, expb, hdc, pw_open;
  logic [15:0] addr, wdata, rdata;
  logic [2:0] ws;
  iocsd_code_t code;
  int n_errors = 0;
  int n_tests = 0;
  localparam logic [15:0] FA[14] = '{16'h0060, 16'h006E, 16'hFC60, 16'h0061,
    16'h00E0, 16'h00FF, 16'h0070, 16'h0071, 16'h0071, 16'h03F2, 16'h03F5,
    16'h03F7, 16'h01F7, 16'h0300};
  localparam logic FW[14] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1,
    1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam logic [4:0] FC[14] = '{5'h01, 5'h01, 5'h01, 5'h1F, 5'h02, 5'h02,
    5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0B, 5'h0C, 5'h1F};
  localparam logic [15:0] SB[4] = '{16'h03F8, 16'h02F8, 16'h03E8, 16'h02E8};
  localparam logic [15:0] PB[3] = '{16'h03BC, 16'h0378, 16'h027F};

  iocsd_host_model host (.core_clk_i(core_clk_i), .io_addr_o(addr),
    .io_wdata_o(wdata), .io_rd_o(rd), .io_wr_o(wr));
  iocsd_decoder dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .io_addr_i(addr),
    .io_wdata_i(wdata), .io_rd_i(rd), .io_wr_i(wr), .ide_mode_i(ide_mode_i),
    .io_rdata_o(rdata), .select_code_lines_o(code), .wait_states_o(ws),
    .bus_16bit_o(b16), .expansion_bus_o(expb), .hd_compressed_o(hdc),
    .password_area_open_o(pw_open));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic dec(input logic w, input logic [15:0] a, input logic [4:0] e);
    host.xfer(w, a, 16'h0000);
    chk(16'(code), 16'(e));
  endtask : dec
  task automatic wreg(input logic [15:0] a, input logic [15:0] d);
    host.xfer(1'b1, a, d);
  endtask : wreg
  task automatic rreg(input logic [15:0] a, input logic [15:0] e);
    host.xfer(1'b0, a, 16'h0000);
    chk(rdata, e);
  endtask : rreg
  task automatic tick;
    @(posedge core_clk_i);
    #1;
  endtask : tick

  task automatic t_reset;
    rreg(`IOCSD_PORT_TIMCTL, 16'h0000);
    rreg(`IOCSD_PORT_SERSEL, 16'h0000);
    rreg(`IOCSD_PORT_PADDR, 16'h0000);
    chk(16'(code), 16'h001F);
    chk(16'(pw_open), 16'h0001);
    chk(16'({ws, b16, expb, hdc}), 16'h0000);
    $display("done reset defaults");
  endtask : t_reset
  task automatic t_regs;
    wreg(`IOCSD_PORT_TIMCTL, 16'hFFFF);
    rreg(`IOCSD_PORT_TIMCTL, `IOCSD_TIMCTL_MASK);
    wreg(`IOCSD_PORT_SERSEL, 16'hFFFF);
    rreg(`IOCSD_PORT_SERSEL, `IOCSD_SERSEL_MASK);
    wreg(`IOCSD_PORT_SERSEL, 16'h0000);
    wreg(`IOCSD_PORT_TIMCTL, 16'h0000);
    rreg(16'h1234, 16'h0000);
    wreg(`IOCSD_PORT_FLUSH, 16'hA5C3);
    chk(16'(code), 16'h0013);
    rreg(`IOCSD_PORT_FLUSH, 16'h0000);
    $display("done register access");
  endtask : t_regs
  task automatic t_fixed;
    for (int i = 0; i < 14; i++) begin
      dec(FW[i], FA[i], FC[i]);
    end
    $display("done fixed decode");
  endtask : t_fixed
  task automatic t_disk;
    wreg(`IOCSD_PORT_TIMCTL, 16'h0002);
    dec(1'b0, 16'h01F0, 5'h1F);
    dec(1'b0, 16'h03F7, 5'h0A);
    wreg(`IOCSD_PORT_TIMCTL, 16'h0001);
    dec(1'b0, 16'h03F2, 5'h1F);
    dec(1'b0, 16'h03F7, 5'h1F);
    dec(1'b0, 16'h01F0, 5'h0C);
    wreg(`IOCSD_PORT_TIMCTL, 16'h0010);
    dec(1'b0, 16'h0372, 5'h08);
    dec(1'b0, 16'h03F2, 5'h1F);
    dec(1'b0, 16'h0171, 5'h0C);
    wreg(`IOCSD_PORT_TIMCTL, 16'h0000);
    $display("done disk selects");
  endtask : t_disk
  // IDE mode through the synchronised pin
  task automatic t_ide;
    @(posedge core_clk_i);
    ide_mode_i <= 1'b1;
    repeat (4) tick;
    dec(1'b0, 16'h03F6, 5'h0D);
    dec(1'b0, 16'h03F7, 5'h0D);
    wreg(`IOCSD_PORT_TIMCTL, 16'h0010);
    dec(1'b0, 16'h0376, 5'h0D);
    dec(1'b0, 16'h0372, 5'h08);
    wreg(`IOCSD_PORT_TIMCTL, 16'h0000);
    @(posedge core_clk_i);
    ide_mode_i <= 1'b0;
    repeat (4) tick;
    $display("done ide mode");
  endtask : t_ide
  task automatic t_serial;
    for (int i = 1; i <= 4; i++) begin
      wreg(`IOCSD_PORT_SERSEL, 16'(i << 5));
      dec(1'b0, SB[i-1] | 16'h0007, 5'h0E);
      wreg(`IOCSD_PORT_SERSEL, 16'(i << 1));
      dec(1'b0, SB[i-1], 5'h10);
    end
    wreg(`IOCSD_PORT_SERSEL, 16'h0022);
    dec(1'b0, 16'h03F8, 5'h0E);
    for (int i = 1; i <= 3; i++) begin
      wreg(`IOCSD_PORT_SERSEL, 16'(i << 9));
      dec(1'b0, PB[i-1], 5'h0F);
    end
    wreg(`IOCSD_PORT_SERSEL, 16'h0000);
    dec(1'b0, 16'h03F8, 5'h1F);
    $display("done serial and printer");
  endtask : t_serial
  task automatic t_prog;
    wreg(`IOCSD_PORT_PADDR, 16'h0A35);
    rreg(`IOCSD_PORT_PADDR, 16'h0A35);
    dec(1'b0, 16'h0235, 5'h1F);
    wreg(`IOCSD_PORT_TIMCTL, 16'h1000);
    dec(1'b0, 16'h0235, 5'h11);
    chk(16'(expb), 16'h0000);
    wreg(`IOCSD_PORT_TIMCTL, 16'h1800);
    dec(1'b0, 16'h0235, 5'h1F);
    dec(1'b0, 16'h0A35, 5'h11);
    for (int k = 0; k <= 4; k++) begin
      wreg(`IOCSD_PORT_TIMCTL, 16'h1800 | 16'(k << 8));
      dec(1'b0, 16'h0A35 ^ 16'(1 << k), 5'h1F);
      if (k > 0) dec(1'b0, 16'h0A35 ^ 16'(1 << (k - 1)), 5'h11);
    end
    wreg(`IOCSD_PORT_TIMCTL, 16'h1080);
    dec(1'b0, 16'h0235, 5'h11);
    chk(16'(expb), 16'h0001);
    wreg(`IOCSD_PORT_PADDR, 16'h0060);
    dec(1'b0, 16'h0060, 5'h01);
    wreg(`IOCSD_PORT_TIMCTL, 16'h0000);
    wreg(`IOCSD_PORT_PADDR, 16'h0000);
    $display("done programmable select");
  endtask : t_prog
  task automatic t_timing;
    wreg(`IOCSD_PORT_SERSEL, 16'h0800);
    dec(1'b0, 16'h3530, 5'h12);
    chk(16'(ws), 16'(`IOCSD_WS_SLOW));
    wreg(`IOCSD_PORT_TIMCTL, 16'h2000);
    dec(1'b1, 16'h3531, 5'h12);
    chk(16'(ws), 16'(`IOCSD_WS_FAST));
    dec(1'b0, 16'h00E0, 5'h02);
    chk(16'(b16), 16'h0000);
    wreg(`IOCSD_PORT_TIMCTL, 16'h0008);
    dec(1'b0, 16'h00E0, 5'h02);
    chk(16'(b16), 16'h0001);
    wreg(`IOCSD_PORT_TIMCTL, 16'h0000);
    wreg(`IOCSD_PORT_SERSEL, 16'h0000);
    $display("done timing");
  endtask : t_timing
  task automatic t_fdisk;
    wreg(`IOCSD_PORT_TIMCTL, 16'h0040);
    dec(1'b0, 16'h01F0, 5'h0C);
    chk(16'(hdc), 16'h0000);
    dec(1'b0, 16'h01F0, 5'h0C);
    chk(16'(hdc), 16'h0001);
    dec(1'b0, 16'h0060, 5'h01);
    dec(1'b0, 16'h01F0, 5'h0C);
    chk(16'(hdc), 16'h0000);
    wreg(`IOCSD_PORT_TIMCTL, 16'h0000);
    dec(1'b0, 16'h01F0, 5'h0C);
    dec(1'b0, 16'h01F0, 5'h0C);
    chk(16'(hdc), 16'h0000);
    $display("done fast disk");
  endtask : t_fdisk
  // Password lock, then a second reset
  task automatic t_lock;
    wreg(`IOCSD_PORT_TIMCTL, 16'h0004);
    wreg(`IOCSD_PORT_LOCK, 16'h0008);
    tick;
    chk(16'(pw_open), 16'h0001);
    wreg(`IOCSD_PORT_TIMCTL, 16'h0000);
    wreg(`IOCSD_PORT_LOCK, 16'h0008);
    tick;
    chk(16'(pw_open), 16'h0000);
    rreg(`IOCSD_PORT_LOCK, 16'h0008);
    wreg(`IOCSD_PORT_TIMCTL, 16'h0004);
    tick;
    chk(16'(pw_open), 16'h0000);
    @(posedge core_clk_i);
    rstn_i <= 1'b0;
    repeat (3) tick;
    chk(16'(pw_open), 16'h0001);
    chk(16'(code), 16'h001F);
    @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rreg(`IOCSD_PORT_TIMCTL, 16'h0000);
    rreg(`IOCSD_PORT_LOCK, 16'h0000);
    $display("done password lock");
  endtask : t_lock

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  // Whole run is a few hundred cycles; this leaves a wide margin
  initial begin
    #200_000;
    n_errors++;
    results;
  end

  initial begin
    rstn_i = 1'b0;
    ide_mode_i = 1'b0;
    repeat (20) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    t_reset;
    t_regs;
    t_fixed;
    t_disk;
    t_ide;
    t_serial;
    t_prog;
    t_timing;
    t_fdisk;
    t_lock;
    results;
  end
endmodule : testbench
